/* File: rtl/pio_pkg.sv */
// package for the parallel input/output port: register map, resets, types
// assumes a single 10 MHz clock domain shared by all users of the package
package pio_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PIO_WIDTH = 32;
    localparam int PIO_IDX_W = 3;

    // ------------------------------------------------------------
    // register word indices
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_PORT_DATA = 3'h0;
    localparam logic [2:0] IDX_LINE_DIRECTION = 3'h1;
    localparam logic [2:0] IDX_IRQ_ENABLE_MASK = 3'h2;
    localparam logic [2:0] IDX_EDGE_LATCH = 3'h3;
    localparam logic [2:0] IDX_OUTPUT_BIT_SET = 3'h4;
    localparam logic [2:0] IDX_OUTPUT_BIT_CLEAR = 3'h5;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [31:0] RST_PORT_DATA = 32'h0000_0000;
    localparam logic [31:0] RST_LINE_DIRECTION = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_ENABLE_MASK = 32'h0000_0000;
    localparam logic [31:0] RST_EDGE_LATCH = 32'h0000_0000;
    localparam logic [31:0] RST_READ_DATA = 32'h0000_0000;

    // ------------------------------------------------------------
    // register port request, one cycle per access
    // ------------------------------------------------------------
    typedef struct packed {
        logic write;
        logic read;
        logic [PIO_IDX_W-1:0] index;
        logic [PIO_WIDTH-1:0] wdata;
    } pio_req_t;

endpackage : pio_pkg

/* File: rtl/pio_port.sv */
// parallel input/output port: data, direction, mask, edge latch, set, clear
// assumes a word-indexed register port from the processor bridge and
// board pins that are asynchronous to the clock
//
// Behaviour
// RULE1 - every register is 32 bits, one per line
// RULE2 - data read returns current input line levels
// RULE3 - data write loads value driven onto outputs
// RULE4 - direction bit 0 input, 1 output
// RULE5 - mask bit 1 enables interrupt for line
// RULE6 - edge latch records edges per input line
// RULE7 - set register write sets selected output bits
// RULE8 - clear register write clears selected output bits
// RULE9 - software treats lamps as active low
// RULE10 - software reaches port through bridge window offset
// RULE11 - interrupt high while masked edge latch bit set
`timescale 1ns/100ps
`default_nettype none

module pio_port
    import pio_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register port
    input wire pio_req_t req,
    output logic [PIO_WIDTH-1:0] readData,
    // board lines
    input wire logic [PIO_WIDTH-1:0] pinIn,
    output logic [PIO_WIDTH-1:0] pinOut,
    output logic [PIO_WIDTH-1:0] pinOe,
    // interrupt
    output logic irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [PIO_WIDTH-1:0] portData;
    logic [PIO_WIDTH-1:0] lineDirection;
    logic [PIO_WIDTH-1:0] irqEnableMask;
    logic [PIO_WIDTH-1:0] edgeLatch;
    logic [PIO_WIDTH-1:0] syncA;
    logic [PIO_WIDTH-1:0] syncB;
    logic [PIO_WIDTH-1:0] syncC;
    logic [PIO_WIDTH-1:0] inLevel;
    logic [PIO_WIDTH-1:0] edgeHit;
    logic [PIO_WIDTH-1:0] next_inLevel;
    logic [PIO_WIDTH-1:0] next_readData;

    logic wrData;
    logic wrDir;
    logic wrMask;
    logic wrEdge;
    logic wrSet;
    logic wrClr;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // one strobe per writable word; indices 6 and 7 are ignored
    // only one index per cycle, so at most one strobe is high
    assign wrData = req.write && (req.index == IDX_PORT_DATA);
    assign wrDir = req.write && (req.index == IDX_LINE_DIRECTION);
    assign wrMask = req.write && (req.index == IDX_IRQ_ENABLE_MASK);
    assign wrEdge = req.write && (req.index == IDX_EDGE_LATCH);
    assign wrSet = req.write && (req.index == IDX_OUTPUT_BIT_SET);
    assign wrClr = req.write && (req.index == IDX_OUTPUT_BIT_CLEAR);

    // ------------------------------------------------------------
    // input synchroniser and filter
    // ------------------------------------------------------------
    // three stages; only syncB reads syncA, so metastability stays put
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= '0;
            syncB <= '0;
            syncC <= '0;
        end else begin
            syncA <= pinIn;
            syncB <= syncA;
            syncC <= syncB;
        end
    end

    // per line: a change counts once the last two stages agree
    genvar gi;
    generate
        for (gi = 0; gi < PIO_WIDTH; gi++) begin : g_line
            always_comb begin
                next_inLevel[gi] = inLevel[gi];
                if (syncB[gi] == syncC[gi]) begin
                    next_inLevel[gi] = syncC[gi];
                end
            end
            // any change of the filtered level is an edge
            assign edgeHit[gi] = next_inLevel[gi] != inLevel[gi]; // RULE6
        end
    endgenerate

    // filtered level, the value a data read returns
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            inLevel <= '0;
        end else begin
            inLevel <= next_inLevel;
        end
    end

    // ------------------------------------------------------------
    // output data register
    // ------------------------------------------------------------
    // set and clear act on the stored value, no read-modify-write needed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            portData <= RST_PORT_DATA;
        end else if (wrData) begin
            portData <= req.wdata; // RULE3
        end else if (wrSet) begin
            portData <= portData | req.wdata; // RULE7
        end else if (wrClr) begin
            portData <= portData & ~req.wdata; // RULE8
        end
    end

    // ------------------------------------------------------------
    // direction and mask
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lineDirection <= RST_LINE_DIRECTION;
        end else if (wrDir) begin
            lineDirection <= req.wdata; // RULE4
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqEnableMask <= RST_IRQ_ENABLE_MASK;
        end else if (wrMask) begin
            irqEnableMask <= req.wdata; // RULE5
        end
    end

    // ------------------------------------------------------------
    // edge latch
    // ------------------------------------------------------------
    // a one written clears a bit; a new edge in that cycle wins
    // lines set as outputs still pass the filter, so the port's own
    // writes show up here once they reach the wire
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            edgeLatch <= RST_EDGE_LATCH;
        end else if (wrEdge) begin
            edgeLatch <= (edgeLatch & ~req.wdata) | edgeHit; // RULE6
        end else begin
            edgeLatch <= edgeLatch | edgeHit; // RULE6
        end
    end

    // ------------------------------------------------------------
    // pins and interrupt
    // ------------------------------------------------------------
    // lamp polarity is left to software, the port drives raw bits
    assign pinOut = portData; // RULE3 RULE9
    assign pinOe = lineDirection; // RULE4

    // registered so the line never glitches on decode
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(edgeLatch & irqEnableMask); // RULE11
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // set and clear words and unused indices read as zero
    // reads have no side effect, so polling keeps the edge latch
    always_comb begin
        next_readData = '0;
        case (req.index)
            IDX_PORT_DATA: next_readData = inLevel; // RULE2
            IDX_LINE_DIRECTION: next_readData = lineDirection;
            IDX_IRQ_ENABLE_MASK: next_readData = irqEnableMask;
            IDX_EDGE_LATCH: next_readData = edgeLatch;
            default: next_readData = '0;
        endcase
    end

    // answer one cycle after the read, held until the next read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            readData <= RST_READ_DATA;
        end else if (req.read) begin
            readData <= next_readData; // RULE1 RULE2
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // every check samples on the rising edge and sleeps during reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_write(logic [2:0] idx);
        req.write && req.index == idx;
    endsequence

    sequence s_pinSteady;
        pinIn == $past(pinIn) [*4];
    endsequence

    sequence s_read(logic [2:0] idx);
        req.read && !req.write && req.index == idx;
    endsequence

    // an edge on an enabled line, with no write to spoil the next cycle
    sequence s_maskedEdge;
        |(edgeHit & irqEnableMask) && !req.write;
    endsequence

    AST_DATA_WRITE: assert property ( // RULE3
        s_write(IDX_PORT_DATA) |=> pinOut == $past(req.wdata))
        else $error("data write not driven on outputs");

    AST_SET_BITS: assert property ( // RULE7
        s_write(IDX_OUTPUT_BIT_SET)
            |=> pinOut == ($past(pinOut) | $past(req.wdata)))
        else $error("set write wrong");

    AST_CLR_BITS: assert property ( // RULE8
        s_write(IDX_OUTPUT_BIT_CLEAR)
            |=> pinOut == ($past(pinOut) & ~$past(req.wdata)))
        else $error("clear write wrong");

    AST_DIR_WRITE: assert property ( // RULE4
        s_write(IDX_LINE_DIRECTION) |=> pinOe == $past(req.wdata))
        else $error("direction write not applied");

    AST_MASK_READBACK: assert property ( // RULE5
        s_write(IDX_IRQ_ENABLE_MASK) ##1 (req.read && !req.write
            && req.index == IDX_IRQ_ENABLE_MASK)
            |=> readData == $past(req.wdata, 2))
        else $error("mask readback wrong");

    AST_INPUT_FOLLOWS: assert property ( // RULE2
        s_pinSteady ##0 (req.read && req.index == IDX_PORT_DATA)
            |=> readData == $past(pinIn))
        else $error("data read not input level");

    AST_EDGE_KEPT: assert property ( // RULE6
        |edgeHit |=> (edgeLatch & $past(edgeHit)) == $past(edgeHit))
        else $error("edge not latched");

    AST_IRQ_LEVEL: assert property ( // RULE11
        ##1 irq == $past(|(edgeLatch & irqEnableMask)))
        else $error("interrupt does not follow masked edges");

    AST_IRQ_HOLD: assert property ( // RULE11
        (|(edgeLatch & irqEnableMask) && !req.write)
            [*2] |-> irq)
        else $error("interrupt dropped while masked edge set");

    // refusals and holding: unmapped words, write-only reads, idle cycles
    AST_UNMAPPED_WRITE: assert property ( // RULE3
        req.write && req.index > IDX_OUTPUT_BIT_CLEAR
            |=> $stable(pinOut) && $stable(pinOe) && $stable(irqEnableMask))
        else $error("write to unmapped word changed state");

    AST_WO_READ_ZERO: assert property ( // RULE7
        s_read(IDX_OUTPUT_BIT_SET) |=> readData == '0)
        else $error("write-only word read back nonzero");

    AST_READ_HOLDS: assert property ( // RULE2
        !req.read |=> $stable(readData))
        else $error("read data changed without a read");

    AST_OE_HOLDS: assert property ( // RULE4
        !(req.write && req.index == IDX_LINE_DIRECTION) |=> $stable(pinOe))
        else $error("output enables changed without a write");

    // an agreeing pair of stages is taken as the new line level
    AST_SYNC_QUIET: assert property ( // RULE2
        syncB == syncC |=> inLevel == $past(syncC))
        else $error("settled input not taken");

    AST_EDGE_CLEAR: assert property ( // RULE6
        s_write(IDX_EDGE_LATCH)
            |=> (edgeLatch & $past(req.wdata) & ~$past(edgeHit)) == '0)
        else $error("edge latch not cleared by write");

    AST_MASK_OFF: assert property ( // RULE5
        irqEnableMask == '0 |=> !irq)
        else $error("interrupt raised with all lines masked");

    AST_EDGE_RAISES_IRQ: assert property ( // RULE11
        s_maskedEdge |=> ##1 irq)
        else $error("masked edge did not raise interrupt");

endmodule : pio_port

`default_nettype wire

/* File: dv/pio_board.sv */
// board model for the port's lines: resolves each wire, shows the lamps
// assumes the bench supplies what the far side drives on undriven lines
`timescale 1ns/100ps
`default_nettype none

module pio_board
    import pio_pkg::*;
(
    // port side
    input wire logic [PIO_WIDTH-1:0] pinOut,
    input wire logic [PIO_WIDTH-1:0] pinOe,
    // far side drive and resolved wire
    input wire logic [PIO_WIDTH-1:0] extDrive,
    output logic [PIO_WIDTH-1:0] pinIn,
    output logic [1:0] lampLit
);
    // port wins where it drives, the outside world elsewhere
    assign pinIn = (pinOut & pinOe) | (extDrive & ~pinOe);
    // lamps glow on a low line
    assign lampLit = ~pinOut[1:0];
endmodule : pio_board

`default_nettype wire

/* File: dv/testbench.sv */
// self-checking bench for the parallel input/output port
// assumes one 10 MHz clock and a one-cycle strobe register port
`timescale 1ns/100ps
`default_nettype none

module testbench
    import pio_pkg::*;
();
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    pio_req_t req = '0;
    logic [31:0] readData, pinIn, pinOut, pinOe, extDrive = 32'h0;
    logic irq;
    logic [1:0] lampLit;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;

    // processor view: bridge window, then the port's place in it
    localparam logic [31:0] LIGHT_BRIDGE_WINDOW_OFFSET = 32'hFF20_0000;
    localparam logic [31:0] LAMP_PORT_OFFSET = 32'h0000_0120;

    // 100 ns period
    always #50 clock = ~clock;

    pio_port dut (.clock(clock), .rst_n(rst_n), .req(req),
        .readData(readData), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .irq(irq));
    pio_board board (.pinOut(pinOut), .pinOe(pinOe), .extDrive(extDrive),
        .pinIn(pinIn), .lampLit(lampLit));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // byte address the processor uses, cut down to the port's word index
    function automatic logic [2:0] word_of(input logic [2:0] idx);
        logic [31:0] lampPortPointer;
        lampPortPointer = LIGHT_BRIDGE_WINDOW_OFFSET + LAMP_PORT_OFFSET
            + {27'h0, idx, 2'b00};
        return lampPortPointer[4:2];
    endfunction : word_of

    // ends off the edge so callers see the settled write effect
    task automatic wr(input logic [2:0] idx, input logic [31:0] d);
        @(posedge clock);
        req <= '{write: 1'b1, read: 1'b0, index: word_of(idx), wdata: d};
        @(posedge clock);
        req <= '0;
        @(negedge clock);
    endtask : wr

    // write then read the same word on the very next edge
    task automatic wr_rd(input logic [2:0] idx, input logic [31:0] d,
                         input string name);
        @(posedge clock);
        req <= '{write: 1'b1, read: 1'b0, index: word_of(idx), wdata: d};
        @(posedge clock);
        req <= '{write: 1'b0, read: 1'b1, index: word_of(idx), wdata: 32'h0};
        @(posedge clock);
        req <= '0;
        @(negedge clock);
        check(name, readData, d);
    endtask : wr_rd

    task automatic rd(input logic [2:0] idx, input logic [31:0] exp,
                      input string name);
        @(posedge clock);
        req <= '{write: 1'b0, read: 1'b1, index: word_of(idx), wdata: 32'h0};
        @(posedge clock);
        req <= '0;
        @(negedge clock);
        check(name, readData, exp);
    endtask : rd

    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // reset values seen at the registers and lines
    task automatic t_reset;
        rd(IDX_PORT_DATA, RST_PORT_DATA, "data");
        rd(IDX_LINE_DIRECTION, RST_LINE_DIRECTION, "dir");
        rd(IDX_IRQ_ENABLE_MASK, RST_IRQ_ENABLE_MASK, "mask");
        rd(IDX_EDGE_LATCH, RST_EDGE_LATCH, "edge");
        check("oe", pinOe, 32'h0000_0000);
    endtask : t_reset

    // direction, data, set and clear back to back; unmapped places
    task automatic t_outputs;
        wr(IDX_LINE_DIRECTION, 32'hFFFF_0003);
        rd(IDX_LINE_DIRECTION, 32'hFFFF_0003, "dir");
        check("oe", pinOe, 32'hFFFF_0003);
        wr(IDX_PORT_DATA, 32'h8000_0003);
        check("out", pinOut, 32'h8000_0003);
        check("lamps", {30'h0, lampLit}, 32'h0000_0000);
        wr(IDX_OUTPUT_BIT_SET, 32'h0000_0010);
        check("set", pinOut, 32'h8000_0013);
        wr(IDX_OUTPUT_BIT_CLEAR, 32'h8000_0001);
        check("clear", pinOut, 32'h0000_0012);
        rd(IDX_OUTPUT_BIT_SET, 32'h0000_0000, "wo set");
        wr(3'h6, 32'hFFFF_FFFF);
        rd(3'h7, 32'h0000_0000, "unmapped");
        check("out", pinOut, 32'h0000_0012);
    endtask : t_outputs

    // inputs, edges, mask and interrupt
    task automatic t_inputs;
        @(posedge clock);
        extDrive <= 32'h0000_A5A4;
        repeat (5) @(posedge clock);
        rd(IDX_PORT_DATA, 32'h0000_A5A6, "pins");
        // lines 0, 1 and 31 toggled as outputs earlier and left edges too
        rd(IDX_EDGE_LATCH, 32'h8000_A5A7, "edge");
        check("irq off", {31'h0, irq}, 32'h0);
        wr_rd(IDX_IRQ_ENABLE_MASK, 32'h0000_0100, "mask");
        check("irq on", {31'h0, irq}, 32'h1);
        wr(IDX_EDGE_LATCH, 32'hFFFF_FFFF);
        rd(IDX_EDGE_LATCH, 32'h0000_0000, "edge clr");
        check("irq clr", {31'h0, irq}, 32'h0);
        @(posedge clock);
        extDrive <= 32'h0000_A4A4;
        repeat (6) @(posedge clock);
        @(negedge clock);
        check("irq fall", {31'h0, irq}, 32'h1);
        rd(IDX_EDGE_LATCH, 32'h0000_0100, "edge fall");
    endtask : t_inputs

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_outputs();
        t_inputs();
        test_done();
    end

    // the run needs some 60 cycles; far more means a hang
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
endmodule : testbench

`default_nettype wire
